// *** six_step_commutation_decoder.sv ***
// The APB register port and the placing of the registers are this design's own decisions.
module six_step_commutation_decoder
  import commutation_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  // Open-collector sensors: high while the sensor pulls its line low
  input wire logic rotor_sensor_a_sink,
  input wire logic rotor_sensor_b_sink,
  input wire logic rotor_sensor_c_sink,
  input wire logic direction_forward,
  input wire logic phasing_sel60,
  // High while something grounds the enable line
  input wire logic run_enable_sink,
  input wire logic current_limit_trip,
  // Open-collector upper drives: level, and enable while sinking
  output logic upper_drive_phase_a_n,
  output logic upper_drive_phase_b_n,
  output logic upper_drive_phase_c_n,
  output logic upper_drive_phase_a_oe,
  output logic upper_drive_phase_b_oe,
  output logic upper_drive_phase_c_oe,
  output logic lower_drive_phase_a,
  output logic lower_drive_phase_b,
  output logic lower_drive_phase_c,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  // ==========================================================
  // State
  // ==========================================================
  state_type state; // All registered state
  state_type next_state; // Its next value
  pins_type pin_level; // Line levels after the pull-ups
  pair_type pair; // Decoded position of the synced code
  logic cycle_start; // Last clock of the oscillator period
  logic run; // Valid position and enabled
  logic upper_keep; // Next value of the PWM latch
  logic lower_keep; // Next value of the current latch
  logic [31:0] status; // Status word
  logic setup_phase; // APB setup cycle
  logic access_write; // APB write taking effect

  // ==========================================================
  // Pin levels
  // ==========================================================
  // Pull-ups make a released line read high
  always_comb begin
    pin_level.sensor = ~{rotor_sensor_a_sink, rotor_sensor_b_sink,
                         rotor_sensor_c_sink};
    pin_level.enable = ~run_enable_sink;
    pin_level.dir = direction_forward;
    pin_level.sel60 = phasing_sel60;
    pin_level.csense = current_limit_trip;
  end

  // ==========================================================
  // Decode and commutation
  // ==========================================================
  // Only the second stage feeds logic, so a metastable first stage
  // can never reach the drives
  always_comb begin
    pair = decode_position(state.sync2.sensor, state.sync2.sel60,
                           state.sync2.dir);
    run = pair.valid && state.sync2.enable;
    cycle_start = (state.count >= state.period - 12'h001);
    setup_phase = psel && !penable;
    access_write = psel && penable && pwrite;
  end

  // Status word, read over APB
  always_comb begin
    status = 32'h0;
    status[STAT_CODE_LSB +: 3] = state.sync2.sensor;
    status[STAT_VALID_BIT] = pair.valid;
    status[STAT_STEP_LSB +: 3] = pair.step;
    status[STAT_LIMIT_BIT] = state.limit_seen;
    status[STAT_ENABLE_BIT] = state.sync2.enable;
    status[STAT_DIR_BIT] = state.sync2.dir;
    status[STAT_SEL_BIT] = state.sync2.sel60;
    status[STAT_PWM_BIT] = state.upper_latch;
  end

  // Next-state logic for everything
  always_comb begin
    next_state = state;
    // Two-stage synchroniser
    next_state.sync1 = pin_level;
    next_state.sync2 = state.sync1;
    // Oscillator ramp; a shortened period restarts it at once
    if (cycle_start) begin
      next_state.count = '0;
    end else begin
      next_state.count = state.count + 12'h001;
    end
    // Latches set only at the period edge, one pulse per cycle
    upper_keep = cycle_start ? 1'b1 : state.upper_latch;
    lower_keep = cycle_start ? 1'b1 : state.lower_latch;
    if (next_state.count >= state.duty) begin
      upper_keep = 1'b0; // PWM compare ends the pulse
    end
    if (state.sync2.csense) begin
      lower_keep = 1'b0;
    end
    next_state.upper_latch = upper_keep;
    next_state.lower_latch = lower_keep;
    // Trip wins over the cycle-start clear
    next_state.limit_seen = state.sync2.csense ||
                            (state.limit_seen && !cycle_start);
    // Upper stays on for the step; only the limit, a coast or a bad code removes it
    if (run && lower_keep) begin
      next_state.upper_n = ~pair.top;
    end else begin
      next_state.upper_n = 3'h7;
    end
    // Lower carries the PWM chopping
    if (run && lower_keep && upper_keep) begin
      next_state.lower = pair.bottom;
    end else begin
      next_state.lower = 3'h0;
    end
    // APB: read data and error prepared in the setup cycle
    if (setup_phase) begin
      next_state.slverr = 1'b0;
      unique case (paddr)
        ADDR_PERIOD: next_state.rdata = {20'h0, state.period};
        ADDR_DUTY: next_state.rdata = {20'h0, state.duty};
        ADDR_STATUS: next_state.rdata = status;
        default: begin
          next_state.rdata = 32'h0;
          next_state.slverr = 1'b1; // Unmapped address
        end
      endcase
    end
    // Writes land in the access cycle; status is read-only
    if (access_write && paddr == ADDR_PERIOD) begin
      if (pwdata < {20'h0, PERIOD_MIN}) begin
        next_state.period = PERIOD_MIN;
      end else if (pwdata > {20'h0, PERIOD_MAX}) begin
        next_state.period = PERIOD_MAX;
      end else begin
        next_state.period = pwdata[CNT_W-1:0];
      end
    end
    if (access_write && paddr == ADDR_DUTY) begin
      // Duty above period simply means full on
      next_state.duty = (pwdata > 32'h0000_0fff) ? 12'hfff :
                        pwdata[CNT_W-1:0];
    end
  end

  // Register the whole state; drives start off
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state <= '{sync1: '0, sync2: '0, count: '0, upper_latch: 1'b0,
                 lower_latch: 1'b0, limit_seen: 1'b0,
                 period: PERIOD_RESET, duty: DUTY_RESET,
                 upper_n: 3'h7, lower: 3'h0, rdata: 32'h0,
                 slverr: 1'b0};
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  always_comb begin
    {upper_drive_phase_a_n, upper_drive_phase_b_n,
     upper_drive_phase_c_n} = state.upper_n;
    {upper_drive_phase_a_oe, upper_drive_phase_b_oe,
     upper_drive_phase_c_oe} = ~state.upper_n;
    {lower_drive_phase_a, lower_drive_phase_b,
     lower_drive_phase_c} = state.lower;
    prdata = state.rdata;
    pready = psel && penable; // Zero wait states
    pslverr = state.slverr && psel && penable;
  end

  // ==========================================================
  // Checks
  // ==========================================================
  logic [1:0] pulses; // Conduction windows opened in this cycle
  logic conduct; // Both latches allow conduction
  logic conduct_prev; // Same, one clock earlier
  logic conduct_rise; // A conduction window opens

  // Coast or a bad code may gate the lower drive off and on inside
  // one cycle; that is no new pulse, so the latch pair is counted
  assign conduct = state.upper_latch && state.lower_latch;
  assign conduct_rise = conduct && !conduct_prev;

  // Count window openings per oscillator cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pulses <= 2'h0;
      conduct_prev <= 1'b0;
    end else begin
      conduct_prev <= conduct;
      if (state.count == 12'h000) begin
        pulses <= {1'b0, conduct_rise};
      end else begin
        pulses <= pulses + {1'b0, conduct_rise};
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence all_off;
    state.upper_n == 3'h7 && state.lower == 3'h0;
  endsequence

  sequence running_step;
    run && !state.sync2.csense && !cycle_start && state.lower_latch;
  endsequence

  a_invalid_off: assert property (
    !pair.valid |=> all_off)
    else $error("drive left on with an invalid sensor code");

  a_code_sets: assert property (
    (!state.sync2.sel60 && state.sync2.sensor inside {3'h0, 3'h7}) ||
    (state.sync2.sel60 && state.sync2.sensor inside {3'h2, 3'h5})
    |-> !pair.valid)
    else $error("invalid code accepted for the selected phasing");

  a_six_sectors: assert property (
    pair.valid |-> pair.step <= STEP_LAST && $onehot(pair.top))
    else $error("valid code gave no single sector");

  a_dir_swap: assert property (
    running_step |=> ~state.upper_n ==
    $past(decode_position(state.sync2.sensor, state.sync2.sel60,
                          !state.sync2.dir).bottom))
    else $error("reverse does not swap upper and lower roles");

  a_coast_low: assert property (
    !state.sync2.enable |=> all_off)
    else $error("drive on while enable is low");

  a_one_pair: assert property (
    running_step |=> $onehot(~state.upper_n) &&
    (state.lower == 3'h0 || $onehot(state.lower)) &&
    ((~state.upper_n & state.lower) == 3'h0))
    else $error("running state lacks one upper and one other lower");

  a_top_no_pwm: assert property (
    running_step ##0 !state.upper_latch |=>
    state.lower == 3'h0 && state.upper_n != 3'h7)
    else $error("upper drive chopped by PWM or lower left on");

  a_trip_off: assert property (
    state.sync2.csense |=> all_off)
    else $error("conduction continued after a current trip");

  a_trip_rest: assert property (
    state.limit_seen && !cycle_start |=> all_off)
    else $error("conduction resumed before the next cycle");

  a_single_pulse: assert property (
    pulses <= 2'h1)
    else $error("more than one lower pulse in a cycle");

  a_lower_gated: assert property (
    (|state.lower) |-> conduct)
    else $error("lower drive on outside the conduction window");

  a_period_range: assert property (
    state.period >= PERIOD_MIN && state.period <= PERIOD_MAX)
    else $error("oscillator period outside allowed range");

  a_sync_delay: assert property (
    run_enable_sink |-> ##3 all_off)
    else $error("grounded enable did not coast after three clocks");

endmodule : six_step_commutation_decoder

// *** commutation_pkg.sv ***
package commutation_pkg;

  // ==========================================================
  // Clock and oscillator timing
  // ==========================================================
  localparam int unsigned CLK_FREQ_HZ = 40_000_000; // System clock rate
  localparam int unsigned OSC_NOMINAL_HZ = 25_000; // Reset switching rate
  localparam int unsigned OSC_MIN_HZ = 20_000; // Slowest allowed rate
  localparam int unsigned OSC_MAX_HZ = 30_000; // Fastest allowed rate
  localparam int CNT_W = 12; // Oscillator counter width
  // Period in clocks; the shortest one rounds up, the longest rounds down
  localparam logic [CNT_W-1:0] PERIOD_RESET =
    CNT_W'(CLK_FREQ_HZ / OSC_NOMINAL_HZ);
  localparam logic [CNT_W-1:0] PERIOD_MIN =
    CNT_W'((CLK_FREQ_HZ + OSC_MAX_HZ - 1) / OSC_MAX_HZ);
  localparam logic [CNT_W-1:0] PERIOD_MAX =
    CNT_W'(CLK_FREQ_HZ / OSC_MIN_HZ);
  localparam logic [CNT_W-1:0] DUTY_RESET = 12'h320; // Half of nominal

  // ==========================================================
  // Register map
  // ==========================================================
  localparam int ADDR_W = 12; // APB address width
  localparam logic [ADDR_W-1:0] ADDR_PERIOD = 12'h000; // Oscillator period
  localparam logic [ADDR_W-1:0] ADDR_DUTY = 12'h004; // PWM compare point
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h008; // Live status
  // Status field positions
  localparam int STAT_CODE_LSB = 0; // Synchronised sensor code, 3 bits
  localparam int STAT_VALID_BIT = 3; // Code is a rotor position
  localparam int STAT_STEP_LSB = 4; // Commutation step, 3 bits
  localparam int STAT_LIMIT_BIT = 7; // Current limit hit this cycle
  localparam int STAT_ENABLE_BIT = 8; // Run enable level
  localparam int STAT_DIR_BIT = 9; // Direction level
  localparam int STAT_SEL_BIT = 10; // Phasing select level
  localparam int STAT_PWM_BIT = 11; // PWM latch still on

  // ==========================================================
  // Phase and step encodings
  // ==========================================================
  localparam logic [2:0] PH_A = 3'h4; // One-hot phase A
  localparam logic [2:0] PH_B = 3'h2; // One-hot phase B
  localparam logic [2:0] PH_C = 3'h1; // One-hot phase C
  localparam logic [2:0] CODE_BAD = 3'h7; // Invalid code in 120 set
  localparam logic [2:0] STEP_NONE = 3'h7; // No valid step
  localparam logic [2:0] STEP_LAST = 3'h5; // Highest valid step

  // ==========================================================
  // Carrier types
  // ==========================================================
  typedef struct packed {
    logic sel60; // High selects the 60 degree code set
    logic dir; // High is forward
    logic enable; // High runs, low coasts
    logic csense; // Over-current comparator output
    logic [2:0] sensor; // {a, b, c} line levels
  } pins_type;

  typedef struct packed {
    logic valid; // Code is a rotor position
    logic [2:0] step; // Step index 0..5
    logic [2:0] top; // Upper switch to close, one-hot, active high
    logic [2:0] bottom; // Lower switch to close, one-hot
  } pair_type;

  typedef struct packed {
    pins_type sync1; // First synchroniser stage
    pins_type sync2; // Second synchroniser stage
    logic [CNT_W-1:0] count; // Oscillator ramp
    logic upper_latch; // Cleared by the PWM compare
    logic lower_latch; // Cleared by the current limit
    logic limit_seen; // Limit tripped in this oscillator cycle
    logic [CNT_W-1:0] period; // Oscillator period in clocks
    logic [CNT_W-1:0] duty; // PWM compare point in clocks
    logic [2:0] upper_n; // Upper drives, low closes the switch
    logic [2:0] lower; // Lower drives, high closes the switch
    logic [31:0] rdata; // APB read data
    logic slverr; // APB error answer
  } state_type;

  // ==========================================================
  // Position decoder, shared by the logic and its checks
  // ==========================================================
  function automatic pair_type decode_position(input logic [2:0] code,
                                               input logic sel60,
                                               input logic dir);
    pair_type p;
    logic [2:0] c;
    logic [2:0] t;
    c = code;
    // Fold the 60 degree set onto the 120 degree set
    if (sel60) begin
      if (code == 3'h7) begin
        c = 3'h2;
      end else if (code == 3'h0) begin
        c = 3'h5;
      end else if (code == 3'h5 || code == 3'h2) begin
        c = CODE_BAD;
      end
    end
    p.valid = 1'b1;
    unique case (c)
      3'h4: begin p.step = 3'h0; p.top = PH_A; p.bottom = PH_C; end
      3'h6: begin p.step = 3'h1; p.top = PH_B; p.bottom = PH_C; end
      3'h2: begin p.step = 3'h2; p.top = PH_B; p.bottom = PH_A; end
      3'h3: begin p.step = 3'h3; p.top = PH_C; p.bottom = PH_A; end
      3'h1: begin p.step = 3'h4; p.top = PH_C; p.bottom = PH_B; end
      3'h5: begin p.step = 3'h5; p.top = PH_A; p.bottom = PH_B; end
      default: begin
        p.valid = 1'b0;
        p.step = STEP_NONE;
        p.top = 3'h0;
        p.bottom = 3'h0;
      end
    endcase
    // Reverse swaps the roles of same-letter switches
    if (!dir) begin
      t = p.top;
      p.top = p.bottom;
      p.bottom = t;
    end
    return p;
  endfunction : decode_position

endpackage : commutation_pkg

// *** hall_bridge_model.sv ***
// ==========================================================
// Hall sensors on one side, MOSFET bridge on the other
// ==========================================================
module hall_bridge_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [2:0] line_code, // Wanted line levels {a, b, c}
  input wire logic [2:0] release_line, // Sensor lines left open
  input wire logic [2:0] upper_n, // Upper drives, low closes
  input wire logic [2:0] lower, // Lower drives, high closes
  output logic [2:0] sink, // Sensor transistor pulls line low
  output logic shoot_seen // Sticky: one leg had both switches on
);
  timeunit 1ns;
  timeprecision 1ps;

  // Open collector: a released line is left to the pull-up, reads high
  assign sink = ~line_code & ~release_line;

  // Watch for a leg with upper and lower closed together
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      shoot_seen <= 1'b0;
    end else if (|(~upper_n & lower)) begin
      shoot_seen <= 1'b1;
    end
  end
endmodule : hall_bridge_model

// *** tb_top.sv ***
// ==========================================================
// Self-checking bench for the commutation decoder
// ==========================================================
module tb_top
  import commutation_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_sys = 1'b0; // 40 MHz
  logic rst; // Async, active high
  logic [2:0] line_code; // Sensor levels asked of the model
  logic [2:0] rel; // Sensor lines forced open
  logic [2:0] sink; // From the sensor model
  logic dir, sel, en_sink, trip; // Control pins
  logic psel, penable, pwrite; // APB request
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, er, shoot;
  logic [2:0] un, oe, lo; // Drive outputs as vectors {a, b, c}
  int errors = 0;
  int num_checks = 0;
  int cycles = 0;
  int seed;
  int i, n, h, g, moves;
  logic [31:0] r;

  always #12.5 clk_sys = ~clk_sys;

  six_step_commutation_decoder dut (
    .clk_sys(clk_sys), .rst(rst),
    .rotor_sensor_a_sink(sink[2]), .rotor_sensor_b_sink(sink[1]),
    .rotor_sensor_c_sink(sink[0]), .direction_forward(dir),
    .phasing_sel60(sel), .run_enable_sink(en_sink),
    .current_limit_trip(trip),
    .upper_drive_phase_a_n(un[2]), .upper_drive_phase_b_n(un[1]),
    .upper_drive_phase_c_n(un[0]), .upper_drive_phase_a_oe(oe[2]),
    .upper_drive_phase_b_oe(oe[1]), .upper_drive_phase_c_oe(oe[0]),
    .lower_drive_phase_a(lo[2]), .lower_drive_phase_b(lo[1]),
    .lower_drive_phase_c(lo[0]),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
  );

  hall_bridge_model partner (
    .clk_sys(clk_sys), .rst(rst), .line_code(line_code),
    .release_line(rel), .upper_n(un), .lower(lo), .sink(sink),
    .shoot_seen(shoot)
  );

  // ==========================================================
  // Reporting
  // ==========================================================
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report

  // Hang guard; the full run needs well under 10k cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      final_report();
    end
  end

  // ==========================================================
  // Expected drives {upper on, lower on}, one-hot per half
  // ==========================================================
  function automatic logic [5:0] expect_drive(input logic [2:0] code,
    input logic s60, input logic fwd, input logic run);
    logic [2:0] c;
    logic [5:0] e;
    c = code;
    // 60 set: two codes fold onto the 120 set, two become invalid
    if (s60) begin
      c = (code == 3'h7) ? 3'h2 : (code == 3'h0) ? 3'h5 :
          (code == 3'h2 || code == 3'h5) ? 3'h0 : code;
    end
    case (c)
      3'h4: e = 6'h21;
      3'h6: e = 6'h11;
      3'h2: e = 6'h14;
      3'h3: e = 6'h0c;
      3'h1: e = 6'h0a;
      3'h5: e = 6'h22;
      default: e = 6'h00; // Invalid code, everything off
    endcase
    // Reverse swaps same-letter roles
    if (!fwd) begin
      e = {e[2:0], e[5:3]};
    end
    return run ? e : 6'h00;
  endfunction : expect_drive

  // ==========================================================
  // Stimulus tasks
  // ==========================================================
  // Set pins, let the two-stage synchroniser and output flops settle
  task automatic apply(input logic [2:0] code, input logic [2:0] open,
    input logic s60, input logic fwd, input logic coast);
    logic [5:0] e;
    logic [2:0] up_exp;
    e = expect_drive(code | open, s60, fwd, !coast);
    up_exp = ~e[5:3];
    @(posedge clk_sys);
    line_code <= code;
    rel <= open;
    sel <= s60;
    dir <= fwd;
    en_sink <= coast;
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
    check("upper_n", un, up_exp);
    check("upper_oe", oe, e[5:3]);
    check("lower", lo, e[2:0]);
  endtask : apply

  // One APB transfer; holds everything until pready is seen high
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
                     input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    // Ends when pready is high; only the bench timeout ends a hang
    while (pready !== 1'b1) begin
      @(posedge clk_sys);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    seed = 32'h92ef87cd;
    rst = 1'b1;
    {psel, penable, pwrite, trip, en_sink, sel} = 6'h00;
    {paddr, pwdata} = '0;
    dir = 1'b1;
    line_code = 3'h4;
    rel = 3'h0;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys);
    check("reset drives", {un, oe, lo}, 32'h1c0);
    // Register defaults, clamping, refusal
    apb(1'b0, ADDR_PERIOD, 32'h0);
    check("period", rd, 32'h640);
    apb(1'b0, ADDR_DUTY, 32'h0);
    check("duty", rd, 32'h320);
    apb(1'b1, ADDR_PERIOD, 32'h10);
    apb(1'b0, ADDR_PERIOD, 32'h0);
    check("period low clamp", rd, 32'h536);
    apb(1'b1, ADDR_PERIOD, 32'hfff);
    apb(1'b0, ADDR_PERIOD, 32'h0);
    check("period high clamp", rd, 32'h7d0);
    apb(1'b1, 12'h00c, 32'h5);
    check("unmapped err", {31'h0, er}, 32'h1);
    apb(1'b1, ADDR_STATUS, 32'h0);
    check("status write err", {31'h0, er}, 32'h0);
    apb(1'b1, ADDR_PERIOD, 32'h536);
    apb(1'b1, ADDR_DUTY, 32'hfff); // Lower on for the whole period
    repeat (2100) @(posedge clk_sys);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check("status code", {28'h0, rd[3:0]}, 32'hc);
    // Every code in both sets and both directions
    for (i = 0; i < 32; i++) begin
      apply(i[2:0], 3'h0, i[3], i[4], 1'b0);
    end
    // Random mix with coasting and open sensor lines
    for (i = 0; i < 40; i++) begin
      r = $random(seed);
      apply(r[2:0], (r[11:10] == 2'b00) ? r[9:7] : 3'h0, r[3], r[4],
            r[6:5] == 2'b00);
    end
    // Current limit: off at once, back only in the next period
    apply(3'h4, 3'h0, 1'b0, 1'b1, 1'b0);
    @(posedge clk_sys);
    trip <= 1'b1;
    @(posedge clk_sys);
    trip <= 1'b0;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    check("trip drives", {un, lo}, 32'h38);
    n = 0;
    while (lo === 3'h0 && n < 3000) begin
      @(negedge clk_sys);
      n++;
    end
    check("trip recovery", {31'h0, n > 0 && n <= 1334}, 32'h1);
    apply(3'h4, 3'h0, 1'b0, 1'b1, 1'b0);
    // PWM: one lower pulse of DUTY clocks per period, upper held
    apb(1'b1, ADDR_DUTY, 32'h190);
    n = 0;
    while (lo !== 3'h0 && n < 3000) begin
      @(negedge clk_sys);
      n++;
    end
    while (lo !== 3'h1 && n < 6000) begin
      @(negedge clk_sys);
      n++;
    end
    h = 0;
    g = 0;
    moves = 0;
    while (lo === 3'h1 && h < 3000) begin
      @(negedge clk_sys);
      h++;
      moves += (un !== 3'h3);
    end
    while (lo === 3'h0 && g < 3000) begin
      @(negedge clk_sys);
      g++;
      moves += (un !== 3'h3);
    end
    check("pwm high", h, 32'd400);
    check("pwm low", g, 32'd934);
    check("upper held", moves, 32'h0);
    check("no shoot through", {31'h0, shoot}, 32'h0);
    final_report();
  end
endmodule : tb_top
